//--- bpp_port.sv
// bidirectional port logic: fourth port and upper two pins of third port
//
// Behaviour
// RULE_01: fourth-port direction bit 1 makes the pin input, driver off
// RULE_02: fourth-port direction bit 0 drives the pin from its latch
// RULE_03: fourth port has eight pins, each with independent direction
// RULE_04: output latch is a register of its own, apart from pin read
// RULE_05: latch reads return latch value, not pin level
// RULE_06: reset sets every fourth-port analog-select bit
// RULE_07: output pin drives latch bit; analog select leaves output alone
// RULE_08: analog select blocks digital input, pin reads give zero; serial receive and clock inputs still see the raw level
// RULE_09: async serial transmit drives upper pin six despite direction 1
// RULE_10: sync serial mode uses pin six as clock, out if master
// RULE_11: async serial mode routes pin seven level to receiver
// RULE_12: sync serial mode uses pin seven as two-way data
// RULE_13: remap bit 0 sends spi data out to pin seven
// RULE_14: unimplemented register bits read zero, writes ignored
// RULE_15: with several peripheral outputs on a pin, highest priority wins
// RULE_16: direction reads return stored value despite peripheral override
// RULE_17: pin levels pass a synchroniser before software reads them
`timescale 1ns/100ps
`include "bpp_cfg.svh"
module bpp_port
  import bpp_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // register port
  input  wire logic [`BPP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // fourth port pins
  input  wire logic [7:0]             port_d_in,
  output logic      [7:0]             port_d_out,
  output logic      [7:0]             port_d_oe,
  // third port upper pins, bit 0 is pin six
  input  wire logic [1:0]             port_c_in,
  output logic      [1:0]             port_c_out,
  output logic      [1:0]             port_c_oe,
  // serial controller
  input  wire logic                   ser_enable,
  input  wire logic                   ser_sync_mode,
  input  wire logic                   ser_tx_data,
  input  wire logic                   ser_clk_master,
  input  wire logic                   ser_clk_out,
  input  wire logic                   ser_data_out,
  input  wire logic                   ser_data_drive,
  output logic                        ser_rx_data,
  output logic                        ser_clk_in,
  // sync serial controller
  input  wire logic                   spi_enable,
  input  wire logic                   spi_data_out,
  // interrupt
  output logic                        irq
);
  // ==========================================================
  // state
  typedef struct packed
  {
    bpp_byte_t d_dir;
    bpp_byte_t d_lat;
    bpp_byte_t d_ans;
    bpp_byte_t c_dir;
    bpp_byte_t c_lat;
    bpp_byte_t c_ans;
    bpp_byte_t slew;
    bpp_byte_t cfg;
    bpp_byte_t stat;
    bpp_byte_t mask;
    bpp_byte_t d_pin;
    bpp_byte_t c_pin;
    bpp_byte_t rdata;
    bpp_byte_t d_out;
    bpp_byte_t d_oe;
    logic [1:0] c_out;
    logic [1:0] c_oe;
    logic      rx;
    logic      ck_in;
    logic      irq;
  } bpp_state_t;

  bpp_state_t st_r;
  bpp_state_t st_nxt;
  logic [7:0] d_sync;
  logic [1:0] c_sync;

  // ==========================================================
  // pin synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_dsync
      bpp_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (port_d_in[gi]),
        .level    (d_sync[gi])
      ); // see RULE_17
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_csync
      bpp_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (port_c_in[gi]),
        .level    (c_sync[gi])
      ); // see RULE_17
    end
  endgenerate

  // byte write with implemented-bit mask
  function automatic bpp_byte_t wr_mask(input bpp_byte_t old,
                                        input bpp_byte_t val,
                                        input bpp_byte_t impl);
    wr_mask = (old & ~impl) | (val & impl);
  endfunction

  // ==========================================================
  // next state
  logic       tx_on;
  logic       sck_drv;
  logic       sdt_drv;
  logic       spi_on;
  logic [1:0] c_dig;
  logic [7:0] ev;

  always_comb
  begin
    st_nxt = st_r;
    tx_on = ser_enable & ~ser_sync_mode;
    sck_drv = ser_enable & ser_sync_mode & ser_clk_master;
    sdt_drv = ser_enable & ser_sync_mode & ser_data_drive;
    spi_on = spi_enable & ~st_r.cfg[`BPP_CFG_REMAP_BIT]; // see RULE_13
    c_dig = c_sync & ~st_r.c_ans[`BPP_PIN_SEVEN:`BPP_PIN_SIX];

    // fourth port: direction and latch per pin
    st_nxt.d_oe = ~st_r.d_dir;          // see RULE_01 see RULE_02 see RULE_03
    st_nxt.d_out = st_r.d_lat;          // see RULE_07
    st_nxt.d_pin = d_sync & ~st_r.d_ans; // see RULE_08

    // pin six: serial takes priority over latch
    if (tx_on)
    begin
      st_nxt.c_oe[0] = 1'b1;            // see RULE_09 see RULE_15
      st_nxt.c_out[0] = ser_tx_data;
    end
    else if (sck_drv)
    begin
      st_nxt.c_oe[0] = 1'b1;            // see RULE_10
      st_nxt.c_out[0] = ser_clk_out;
    end
    else if (ser_enable)
    begin
      st_nxt.c_oe[0] = 1'b0;            // see RULE_10
      st_nxt.c_out[0] = st_r.c_lat[`BPP_PIN_SIX];
    end
    else
    begin
      st_nxt.c_oe[0] = ~st_r.c_dir[`BPP_PIN_SIX];
      st_nxt.c_out[0] = st_r.c_lat[`BPP_PIN_SIX];
    end

    // pin seven: spi over serial data over latch
    if (spi_on)
    begin
      st_nxt.c_oe[1] = 1'b1;            // see RULE_13 see RULE_15
      st_nxt.c_out[1] = spi_data_out;
    end
    else if (sdt_drv)
    begin
      st_nxt.c_oe[1] = 1'b1;            // see RULE_12
      st_nxt.c_out[1] = ser_data_out;
    end
    else if (ser_enable)
    begin
      st_nxt.c_oe[1] = 1'b0;            // see RULE_11 see RULE_12
      st_nxt.c_out[1] = st_r.c_lat[`BPP_PIN_SEVEN];
    end
    else
    begin
      st_nxt.c_oe[1] = ~st_r.c_dir[`BPP_PIN_SEVEN];
      st_nxt.c_out[1] = st_r.c_lat[`BPP_PIN_SEVEN];
    end

    // peripheral inputs use the raw synchronised level, not analog-gated
    st_nxt.rx = c_sync[1];              // see RULE_11 see RULE_12
    st_nxt.ck_in = c_sync[0];           // see RULE_10
    st_nxt.c_pin = {c_dig, 6'h00};      // see RULE_08 see RULE_14

    // events: rising digital level on the two third-port pins and pin 0..5
    ev = {c_dig & ~st_r.c_pin[7:6], d_sync[5:0] & ~st_r.d_ans[5:0]
          & ~st_r.d_pin[5:0]};

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `BPP_OFF_D_DIR:
        begin
          st_nxt.d_dir = reg_wdata;
        end
        `BPP_OFF_D_LAT:
        begin
          st_nxt.d_lat = reg_wdata;  // see RULE_04
        end
        // a write to the pin-level index lands in the latch
        `BPP_OFF_D_PIN:
        begin
          st_nxt.d_lat = reg_wdata;
        end
        `BPP_OFF_D_ANS:
        begin
          st_nxt.d_ans = reg_wdata;
        end
        `BPP_OFF_C_DIR:
        begin
          st_nxt.c_dir =
            wr_mask(st_r.c_dir, reg_wdata, `BPP_C_IMPL); // see RULE_14
        end
        `BPP_OFF_C_LAT, `BPP_OFF_C_PIN:
        begin
          st_nxt.c_lat =
            wr_mask(st_r.c_lat, reg_wdata, `BPP_C_IMPL);
        end
        `BPP_OFF_C_ANS:
        begin
          st_nxt.c_ans =
            wr_mask(st_r.c_ans, reg_wdata, `BPP_C_IMPL);
        end
        `BPP_OFF_SLEW:
        begin
          st_nxt.slew = reg_wdata & `BPP_SLEW_IMPL;
        end
        `BPP_OFF_CFG:
        begin
          st_nxt.cfg = {7'h00, reg_wdata[0]};
        end
        `BPP_OFF_IRQ_MASK:
        begin
          st_nxt.mask = reg_wdata;
        end
        default: ;
      endcase
    end
    // write-one-to-clear; a new event wins over the clear
    if (reg_wr && reg_addr == `BPP_OFF_IRQ_STAT)
    begin
      st_nxt.stat = (st_r.stat & ~reg_wdata) | ev;
    end
    else
    begin
      st_nxt.stat = st_r.stat | ev;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // register reads, data in the following cycle only
    st_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `BPP_OFF_D_DIR:
        begin
          st_nxt.rdata = st_r.d_dir;
        end
        `BPP_OFF_D_LAT:
        begin
          st_nxt.rdata = st_r.d_lat;   // see RULE_05
        end
        `BPP_OFF_D_PIN:
        begin
          st_nxt.rdata = st_r.d_pin;
        end
        `BPP_OFF_D_ANS:
        begin
          st_nxt.rdata = st_r.d_ans;
        end
        `BPP_OFF_C_DIR:
        begin
          st_nxt.rdata = st_r.c_dir;   // see RULE_16
        end
        `BPP_OFF_C_LAT:
        begin
          st_nxt.rdata = st_r.c_lat;   // see RULE_05
        end
        `BPP_OFF_C_PIN:
        begin
          st_nxt.rdata = st_r.c_pin;
        end
        `BPP_OFF_C_ANS:
        begin
          st_nxt.rdata = st_r.c_ans;
        end
        `BPP_OFF_SLEW:
        begin
          st_nxt.rdata = st_r.slew;
        end
        `BPP_OFF_CFG:
        begin
          st_nxt.rdata = st_r.cfg;
        end
        `BPP_OFF_IRQ_STAT:
        begin
          st_nxt.rdata = st_r.stat;
        end
        `BPP_OFF_IRQ_MASK:
        begin
          st_nxt.rdata = st_r.mask;
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.d_dir <= `BPP_RST_DIR;
      st_r.d_lat <= `BPP_RST_LAT;
      st_r.d_ans <= `BPP_RST_ANS;               // see RULE_06
      st_r.c_dir <= `BPP_RST_DIR & `BPP_C_IMPL;
      st_r.c_lat <= `BPP_RST_LAT;
      st_r.c_ans <= `BPP_RST_ANS & `BPP_C_IMPL;
      st_r.slew <= `BPP_RST_SLEW;
      st_r.cfg <= `BPP_RST_CFG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all registered
  assign reg_rdata = st_r.rdata;
  assign port_d_out = st_r.d_out;
  assign port_d_oe = st_r.d_oe;
  assign port_c_out = st_r.c_out;
  assign port_c_oe = st_r.c_oe;
  assign ser_rx_data = st_r.rx;
  assign ser_clk_in = st_r.ck_in;
  assign irq = st_r.irq;
endmodule

//--- bpp_cfg.svh
// register offsets, field positions and reset values for the port block
`ifndef BPP_CFG_SVH
`define BPP_CFG_SVH
`define BPP_ADDR_W        4
`define BPP_OFF_D_DIR     4'h0
`define BPP_OFF_D_LAT     4'h1
`define BPP_OFF_D_PIN     4'h2
`define BPP_OFF_D_ANS     4'h3
`define BPP_OFF_C_DIR     4'h4
`define BPP_OFF_C_LAT     4'h5
`define BPP_OFF_C_PIN     4'h6
`define BPP_OFF_C_ANS     4'h7
`define BPP_OFF_SLEW      4'h8
`define BPP_OFF_CFG       4'h9
`define BPP_OFF_IRQ_STAT  4'ha
`define BPP_OFF_IRQ_MASK  4'hb
`define BPP_C_IMPL        8'hc0
`define BPP_SLEW_IMPL     8'h1f
`define BPP_RST_DIR       8'hff
`define BPP_RST_ANS       8'hff
`define BPP_RST_LAT       8'h00
`define BPP_RST_SLEW      8'h1f
`define BPP_RST_CFG       8'h01
`define BPP_CFG_REMAP_BIT 0
`define BPP_PIN_SIX       6
`define BPP_PIN_SEVEN     7
`endif

//--- bpp_pkg.sv
// types shared by the port block files
package bpp_pkg;
  typedef logic [7:0] bpp_byte_t;
  typedef struct packed
  {
    logic [2:0] s1;
    logic       val;
  } bpp_sync_t;
endpackage

//--- bpp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module bpp_sync
  import bpp_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // pin side
  input  wire logic pin_in,
  // core side
  output logic      level
);
  bpp_sync_t st_r;
  bpp_sync_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {st_r.s1[1:0], pin_in};
    // first stage only feeds the second; change once stages 2 and 3 agree
    if (st_r.s1[1] == st_r.s1[2])
    begin
      st_nxt.val = st_r.s1[2];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.val;
endmodule

//--- bpp_port_monitor.sv
// assertion checker for the port block
`timescale 1ns/100ps
`include "bpp_cfg.svh"
module bpp_port_monitor
  import bpp_pkg::*;
(
  // clock and reset
  input logic                   core_clk,
  input logic                   rst,
  // register port
  input logic [`BPP_ADDR_W-1:0] reg_addr,
  input logic [7:0]             reg_wdata,
  input logic                   reg_wr,
  input logic                   reg_rd,
  input logic [7:0]             reg_rdata,
  // pins
  input logic [7:0]             port_d_out,
  input logic [7:0]             port_d_oe,
  input logic [1:0]             port_c_out,
  input logic [1:0]             port_c_oe,
  // peripherals
  input logic                   ser_enable,
  input logic                   ser_sync_mode,
  input logic                   ser_tx_data,
  input logic                   ser_clk_master,
  input logic                   ser_clk_out,
  input logic                   ser_data_out,
  input logic                   ser_data_drive,
  input logic                   spi_enable
);
  // ==========
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sync_on;
  assign sync_on = ser_enable & ser_sync_mode;
  sequence s_dir_wr;
    reg_wr && reg_addr == 4'h0;
  endsequence
  sequence s_lat_wr;
    reg_wr && reg_addr == 4'h1;
  endsequence
  chk_dir_oe:
    assert property (s_dir_wr |-> ##2 port_d_oe == ~$past(reg_wdata, 2))
    else $error("driver enable differs from direction");
  chk_lat_out:
    assert property (s_lat_wr |-> ##2
      ((port_d_out ^ $past(reg_wdata, 2)) & port_d_oe) == 8'h00)
    else $error("driven pin differs from latch");
  chk_rd_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero:
    assert property (reg_rd && reg_addr > 4'hb |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_c_unimpl:
    assert property (reg_rd && reg_addr[3:2] == 2'b01 |=>
      reg_rdata[5:0] == 6'h00)
    else $error("unimplemented bits not zero");
  chk_tx_pin:
    assert property (ser_enable && !ser_sync_mode |=>
      port_c_oe[0] && port_c_out[0] == $past(ser_tx_data))
    else $error("transmit not on pin six");
  chk_clk_drive:
    assert property (sync_on && ser_clk_master |=>
      port_c_oe[0] && port_c_out[0] == $past(ser_clk_out))
    else $error("serial clock not driven");
  chk_clk_input:
    assert property (sync_on && !ser_clk_master |=> !port_c_oe[0])
    else $error("serial clock input driven");
  chk_data_drive:
    assert property (sync_on && ser_data_drive && !spi_enable |=>
      port_c_oe[1] && port_c_out[1] == $past(ser_data_out))
    else $error("serial data not driven");
endmodule

//--- bpp_board.sv
// board model: external drivers and pull-downs on the port pins
`timescale 1ns/100ps
module bpp_board
(
  // device side
  input  logic [9:0] drv_oe,
  input  logic [9:0] drv_out,
  // test side
  input  logic [9:0] ext,
  input  logic [9:0] ext_en,
  // resolved levels
  output logic [9:0] pin
);
  // ==========
  // pull-downs: a released pin reads low, never its old level
  assign pin = (drv_oe & drv_out) | (~drv_oe & ext_en & ext);
endmodule

//--- bpp_port_test.sv
// self-checking bench for the port block
`timescale 1ns/100ps
module bpp_port_test
  import bpp_pkg::*;
;
  // ==========
  // signals
  logic       core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_pend = 0;
  logic [3:0] reg_addr = 0;
  bpp_byte_t  reg_wdata = 0, reg_rdata, port_d_out, port_d_oe, lat;
  wire  [7:0] port_d_in;
  wire  [1:0] port_c_in;
  logic [1:0] port_c_out, port_c_oe;
  logic       ser_enable = 0, ser_sync_mode = 0, ser_tx_data = 0;
  logic       ser_clk_master = 0, ser_clk_out = 0, ser_data_out = 0;
  logic       ser_data_drive = 0, spi_enable = 0, spi_data_out = 0;
  logic       ser_rx_data, ser_clk_in, irq;
  logic [9:0] ext = 0, ext_en = 0;
  bpp_byte_t  exp_q[$];
  bpp_byte_t  rst_tab[16] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hc0, 8'h00,
    8'h00, 8'hc0, 8'h1f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int         fails = 0, total_checks = 0, cyc = 0;
  initial forever #10 core_clk = ~core_clk;
  bpp_port bpp_port_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_d_in, .port_d_out, .port_d_oe, .port_c_in,
    .port_c_out, .port_c_oe, .ser_enable, .ser_sync_mode, .ser_tx_data,
    .ser_clk_master, .ser_clk_out, .ser_data_out, .ser_data_drive,
    .ser_rx_data, .ser_clk_in, .spi_enable, .spi_data_out, .irq);
  bpp_board bpp_board_inst (.drv_oe({port_c_oe, port_d_oe}),
    .drv_out({port_c_out, port_d_out}), .ext, .ext_en,
    .pin({port_c_in, port_d_in}));
  // ==========
  // tasks
  task automatic chk(string nm, bpp_byte_t e, bpp_byte_t g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, bpp_byte_t d);
    reg_wr <= 1;
    reg_rd <= 0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [3:0] a, bpp_byte_t e);
    exp_q.push_back(e);
    reg_rd <= 1;
    reg_wr <= 0;
    reg_addr <= a;
    @(posedge core_clk);
  endtask
  task automatic idle();
    reg_wr <= 0;
    reg_rd <= 0;
    @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // read watcher and hang limit
  always @(posedge core_clk)
  begin
    cyc++;
    if (rd_pend)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_pend <= reg_rd;
    if (cyc == 2000)
    begin
      fails++;
      end_of_test();
    end
  end
  // ==========
  // main sequence
  initial
  begin
    lat = 8'($urandom(22));
    repeat (4) @(posedge core_clk);
    rst <= 0;
    chk("port_d_oe", 8'h00, port_d_oe);
    for (int i = 0; i < 16; i++)
      if (i != 11)
        rd(4'(i), rst_tab[i]);
    wr(4'h3, 8'h00);
    wr(4'h1, lat);
    wr(4'h0, 8'hf0);
    ext[7:4] <= ~lat[7:4];
    ext_en[7:4] <= 4'hf;
    repeat (8) idle();
    chk("port_d_oe", 8'h0f, port_d_oe);
    chk("port_d_out", lat & 8'h0f, port_d_out & 8'h0f);
    rd(4'h2, {~lat[7:4], lat[3:0]});
    rd(4'h1, lat);
    // interrupt: a set mask bit lets its status bit through
    ext[4] <= 1'b0;
    wr(4'hb, 8'hff);
    repeat (6) idle();
    wr(4'ha, 8'hff);
    ext[4] <= 1'b1;
    repeat (6) idle();
    rd(4'ha, 8'h10);
    chk("irq", 8'h01, {7'h0, irq});
    wr(4'hb, 8'hef);
    repeat (2) idle();
    chk("irq", 8'h00, {7'h0, irq});
    // clear under a full mask: a stuck status bit would raise irq
    wr(4'ha, 8'h10);
    wr(4'hb, 8'hff);
    repeat (2) idle();
    chk("irq", 8'h00, {7'h0, irq});
    wr(4'h3, 8'hf0);
    repeat (6) idle();
    rd(4'h2, {4'h0, lat[3:0]});
    chk("port_d_out", lat & 8'h0f, port_d_out & 8'h0f);
    repeat (40)
    begin
      {ser_enable, ser_sync_mode, ser_clk_master, ser_data_drive, ser_tx_data,
       ser_clk_out, ser_data_out, spi_data_out} <= 8'($urandom);
      idle();
    end
    {ser_enable, ser_sync_mode, ser_clk_master, ser_data_drive} <= 4'hc;
    ext[9:8] <= 2'b10;
    ext_en[9:8] <= 2'b11;
    rd(4'h4, 8'hc0);
    repeat (6) idle();
    chk("serial in", 8'h02, {6'h0, ser_rx_data, ser_clk_in});
    ser_sync_mode <= 1'b0;
    ext[9:8] <= 2'b01;
    repeat (6) idle();
    chk("ser_rx_data", 8'h00, {7'h0, ser_rx_data});
    wr(4'h9, 8'hff);
    wr(4'h4, 8'hff);
    rd(4'h9, 8'h01);
    rd(4'h4, 8'hc0);
    wr(4'h6, 8'hff);
    rd(4'h5, 8'hc0);
    wr(4'h9, 8'h00);
    {spi_enable, spi_data_out, ser_sync_mode, ser_data_drive,
     ser_data_out} <= 5'h1e;
    repeat (3) idle();
    chk("pin seven oe", 8'h01, {7'h0, port_c_oe[1]});
    chk("pin seven out", 8'h01, {7'h0, port_c_out[1]});
    repeat (2) idle();
    end_of_test();
  end
endmodule
bind bpp_port bpp_port_monitor bpp_port_monitor_inst (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_d_out,
  .port_d_oe, .port_c_out, .port_c_oe, .ser_enable, .ser_sync_mode,
  .ser_tx_data, .ser_clk_master, .ser_clk_out, .ser_data_out,
  .ser_data_drive, .spi_enable);
